// File: design/pin_mux_defs.svh
// register offsets, reset values and field positions of the pin mux
// Function
// - upper select register at C22h, resets zero
// - bit n steers pin sixteen plus n
// - clear means I/O, set means interface
// - bits 15..12 give serial two modem inputs
// - bit 11 gives bus chip select zero
// - bit 10 gives wide memory indication
// - bit 9 gives wide I/O indication
// - bit 8 gives data buffer enable
// - bits 7..0 give interrupt requests 0..7
// - after reset all pins are I/O inputs
// - 32-bit C20h access: lower then upper half
// - chip select register at C24h, bit0 reserved
// - set bit picks bus chip select 7..1
`ifndef PIN_MUX_DEFS_SVH
`define PIN_MUX_DEFS_SVH
`define LOWER_SEL_OFFSET 12'hC20
`define UPPER_SEL_OFFSET 12'hC22
`define CS_SEL_OFFSET 12'hC24
`define UPPER_SEL_RESET 16'h0000
`define CS_SEL_RESET 8'h00
`define CS_SEL_WRITE_MASK 8'hFE
`define SERIAL_FIRST_BIT 12
`define CHIP_SEL0_BIT 11
`define WIDE_MEM_BIT 10
`define WIDE_IO_BIT 9
`define BUF_OE_BIT 8
`endif

// File: design/pin_mux_pkg.sv
// types shared by the pin function select block
`default_nettype none
package pin_mux_pkg;
  // phases of a split double-width access
  typedef enum logic [1:0] {
    ph_idle = 2'b01,
    ph_upper = 2'b10
  } phase_t;
endpackage
`default_nettype wire

// File: design/pio_pin_function_select.sv
// pin function select registers and routing for pins 31..16
`include "pin_mux_defs.svh"
`default_nettype none
module pio_pin_function_select (
  input wire logic ref_clk, // system clock
  input wire logic srst, // synchronous reset, high
  input wire logic clk_en, // freezes all state when low; srst still resets
  input wire logic cfg_req, // access request, one cycle
  input wire logic cfg_wr, // 1 write, 0 read
  input wire logic cfg_dword, // 32-bit access at C20h
  input wire logic [11:0] cfg_addr, // byte offset in config region
  input wire logic [31:0] cfg_wdata, // write data
  output logic [31:0] cfg_rdata, // read data
  output logic cfg_ack, // access done pulse
  output logic lower_wr_stb, // lower half write pulse to owner
  output logic [15:0] lower_wr_data, // lower half data
  output logic [15:0] pio_func_sel, // per pin 31..16: 1 interface
  output logic [3:0] serial2_modem_sel, // ri,dcd,dsr,cts routed
  output logic bus_chip_select_zero_sel, // pin 27 routing
  output logic bus_wide_memory_indication_sel, // pin 26 routing
  output logic bus_wide_io_indication_sel, // pin 25 routing
  output logic bus_data_buffer_output_enable_sel, // pin 24 routing
  output logic [7:0] bus_irq_sel, // bit k: request k routed
  output logic [7:0] cs_func_sel // chip select function bits
);
  // register state
  logic [15:0] upper_pin_function_select; // upper select register
  logic [7:0] chip_select_pin_function; // chip select register
  pin_mux_pkg::phase_t phase; // split access phase
  logic [15:0] pend_upper; // upper half held for second step
  logic pend_wr; // pending step is a write
  // next values
  logic [15:0] next_upper;
  logic [7:0] next_cs;
  pin_mux_pkg::phase_t next_phase;
  logic [15:0] next_pend_upper;
  logic next_pend_wr;
  logic [31:0] next_rdata;
  logic next_ack;
  logic next_lower_stb;
  logic [15:0] next_lower_data;
  logic [15:0] next_sel;
  logic [3:0] next_modem;
  logic next_cs0, next_mem, next_io, next_oe;
  logic [7:0] next_irq;
  logic [7:0] next_cs_out;

  // register access decode and split sequencing
  always_comb
  begin
    next_upper = upper_pin_function_select;
    next_cs = chip_select_pin_function;
    next_phase = phase;
    next_pend_upper = pend_upper;
    next_pend_wr = pend_wr;
    next_rdata = 32'h0000_0000;
    next_ack = 1'b0;
    next_lower_stb = 1'b0;
    next_lower_data = 16'h0000;
    unique case (phase)
      pin_mux_pkg::ph_idle:
      begin
        if (cfg_req)
        begin
          if (cfg_dword && cfg_addr == `LOWER_SEL_OFFSET)
          begin
            next_lower_stb = cfg_wr;
            next_lower_data = cfg_wdata[15:0];
            next_pend_upper = cfg_wdata[31:16];
            next_pend_wr = cfg_wr;
            next_phase = pin_mux_pkg::ph_upper;
          end
          else if (cfg_addr == `UPPER_SEL_OFFSET)
          begin
            if (cfg_wr)
              next_upper = cfg_wdata[15:0];
            next_rdata = {16'h0000, upper_pin_function_select};
            next_ack = 1'b1;
          end
          else if (cfg_addr == `CS_SEL_OFFSET)
          begin
            if (cfg_wr)
              next_cs = cfg_wdata[7:0] & `CS_SEL_WRITE_MASK;
            next_rdata = {24'h000000, chip_select_pin_function};
            next_ack = 1'b1;
          end
          // unmapped or lower-only: acknowledged, reads zero
          else
            next_ack = 1'b1;
        end
      end
      pin_mux_pkg::ph_upper:
      begin
        if (pend_wr)
          next_upper = pend_upper;
        next_rdata = {upper_pin_function_select, 16'h0000};
        next_ack = 1'b1;
        next_phase = pin_mux_pkg::ph_idle;
      end
    endcase
  end

  // routing decode from the registered selects
  always_comb
  begin
    // bit n is pin sixteen plus n
    next_sel = upper_pin_function_select;
    next_modem = upper_pin_function_select[15:`SERIAL_FIRST_BIT];
    next_cs0 = upper_pin_function_select[`CHIP_SEL0_BIT];
    next_mem = upper_pin_function_select[`WIDE_MEM_BIT];
    next_io = upper_pin_function_select[`WIDE_IO_BIT];
    next_oe = upper_pin_function_select[`BUF_OE_BIT];
    for (int k = 0; k < 8; k++)
      next_irq[k] = upper_pin_function_select[7 - k];
    next_cs_out = chip_select_pin_function;
  end

  // registers; reset leaves all pins I/O
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      upper_pin_function_select <= `UPPER_SEL_RESET;
      chip_select_pin_function <= `CS_SEL_RESET;
      phase <= pin_mux_pkg::ph_idle;
      pend_upper <= 16'h0000;
      pend_wr <= 1'b0;
      cfg_rdata <= 32'h0000_0000;
      cfg_ack <= 1'b0;
      lower_wr_stb <= 1'b0;
      lower_wr_data <= 16'h0000;
      pio_func_sel <= 16'h0000;
      serial2_modem_sel <= 4'h0;
      bus_chip_select_zero_sel <= 1'b0;
      bus_wide_memory_indication_sel <= 1'b0;
      bus_wide_io_indication_sel <= 1'b0;
      bus_data_buffer_output_enable_sel <= 1'b0;
      bus_irq_sel <= 8'h00;
      cs_func_sel <= 8'h00;
    end
    else if (clk_en)
    begin
      upper_pin_function_select <= next_upper;
      chip_select_pin_function <= next_cs;
      phase <= next_phase;
      pend_upper <= next_pend_upper;
      pend_wr <= next_pend_wr;
      cfg_rdata <= next_rdata;
      cfg_ack <= next_ack;
      lower_wr_stb <= next_lower_stb;
      lower_wr_data <= next_lower_data;
      pio_func_sel <= next_sel;
      serial2_modem_sel <= next_modem;
      bus_chip_select_zero_sel <= next_cs0;
      bus_wide_memory_indication_sel <= next_mem;
      bus_wide_io_indication_sel <= next_io;
      bus_data_buffer_output_enable_sel <= next_oe;
      bus_irq_sel <= next_irq;
      cs_func_sel <= next_cs_out;
    end
  end

  // split access sequence pieces
  sequence s_dword_req;
    cfg_req && cfg_dword && cfg_addr == `LOWER_SEL_OFFSET
      && phase == pin_mux_pkg::ph_idle;
  endsequence
  sequence s_upper_step;
    !lower_wr_stb ##0 cfg_ack;
  endsequence
  sequence s_single_req;
    cfg_req && clk_en && phase == pin_mux_pkg::ph_idle
      && !(cfg_dword && cfg_addr == `LOWER_SEL_OFFSET);
  endsequence
  sequence s_dword_wr;
    (s_dword_req and (cfg_wr && clk_en)) ##1 clk_en;
  endsequence

  property p_split_order;
    @(posedge ref_clk) disable iff (srst)
    ((s_dword_req and clk_en) ##1 clk_en) |=> s_upper_step;
  endproperty
  a_split_order: assert property (p_split_order)
    else $error("split access not in two steps");

  property p_lower_first;
    @(posedge ref_clk) disable iff (srst)
    (s_dword_req and (cfg_wr && clk_en)) |=> lower_wr_stb && !cfg_ack;
  endproperty
  a_lower_first: assert property (p_lower_first)
    else $error("lower half not written first");

  property p_upper_write;
    @(posedge ref_clk) disable iff (srst)
    (cfg_req && cfg_wr && !cfg_dword && clk_en
      && cfg_addr == `UPPER_SEL_OFFSET && phase == pin_mux_pkg::ph_idle)
      |=> upper_pin_function_select == $past(cfg_wdata[15:0]);
  endproperty
  a_upper_write: assert property (p_upper_write)
    else $error("upper select write lost");

  property p_cs_reserved;
    @(posedge ref_clk) disable iff (srst)
    1'b1 |-> !chip_select_pin_function[0] && !cs_func_sel[0];
  endproperty
  a_cs_reserved: assert property (p_cs_reserved)
    else $error("reserved chip select bit set");

  property p_route_lag;
    @(posedge ref_clk) disable iff (srst)
    (clk_en && $changed(upper_pin_function_select))
      |-> pio_func_sel == $past(upper_pin_function_select) ##1
      (!clk_en || pio_func_sel == $past(upper_pin_function_select));
  endproperty
  a_route_lag: assert property (p_route_lag)
    else $error("routing lag wrong");

  property p_irq_order;
    @(posedge ref_clk) disable iff (srst)
    1'b1 |-> bus_irq_sel[0] == pio_func_sel[7]
      && bus_irq_sel[7] == pio_func_sel[0];
  endproperty
  a_irq_order: assert property (p_irq_order)
    else $error("interrupt request order wrong");

  property p_modem;
    @(posedge ref_clk) disable iff (srst)
    1'b1 |-> serial2_modem_sel == pio_func_sel[15:12]
      && bus_chip_select_zero_sel == pio_func_sel[11];
  endproperty
  a_modem: assert property (p_modem)
    else $error("modem or chip select routing wrong");

  property p_bus_lines;
    @(posedge ref_clk) disable iff (srst)
    1'b1 |-> bus_wide_memory_indication_sel == pio_func_sel[10]
      && bus_wide_io_indication_sel == pio_func_sel[9]
      && bus_data_buffer_output_enable_sel == pio_func_sel[8];
  endproperty
  a_bus_lines: assert property (p_bus_lines)
    else $error("bus line routing wrong");

  property p_reset_io;
    @(posedge ref_clk) srst |=> pio_func_sel == 16'h0000
      && cs_func_sel == 8'h00;
  endproperty
  a_reset_io: assert property (p_reset_io)
    else $error("pins not I/O after reset");

  property p_single_ack;
    @(posedge ref_clk) disable iff (srst)
    s_single_req |=> cfg_ack && !lower_wr_stb;
  endproperty
  a_single_ack: assert property (p_single_ack)
    else $error("single access not answered");

  property p_cs_write;
    @(posedge ref_clk) disable iff (srst)
    (s_single_req and (cfg_wr && cfg_addr == `CS_SEL_OFFSET))
      |=> chip_select_pin_function
        == ($past(cfg_wdata[7:0]) & `CS_SEL_WRITE_MASK);
  endproperty
  a_cs_write: assert property (p_cs_write)
    else $error("chip select write wrong");

  property p_cs_route;
    @(posedge ref_clk) disable iff (srst)
    clk_en |=> cs_func_sel == $past(chip_select_pin_function);
  endproperty
  a_cs_route: assert property (p_cs_route)
    else $error("chip select routing wrong");

  property p_route_follow;
    @(posedge ref_clk) disable iff (srst)
    clk_en |=> pio_func_sel == $past(upper_pin_function_select);
  endproperty
  a_route_follow: assert property (p_route_follow)
    else $error("pin routing not one stage behind");

  property p_lower_data;
    @(posedge ref_clk) disable iff (srst)
    (s_dword_req and (cfg_wr && clk_en))
      |=> lower_wr_data == $past(cfg_wdata[15:0]);
  endproperty
  a_lower_data: assert property (p_lower_data)
    else $error("lower half data wrong");

  property p_upper_second;
    @(posedge ref_clk) disable iff (srst)
    s_dword_wr
      |=> upper_pin_function_select == $past(cfg_wdata[31:16], 2);
  endproperty
  a_upper_second: assert property (p_upper_second)
    else $error("upper half not written second");

  property p_unmapped_read;
    @(posedge ref_clk) disable iff (srst)
    (s_single_req and (!cfg_wr && cfg_addr != `UPPER_SEL_OFFSET
      && cfg_addr != `CS_SEL_OFFSET)) |=> cfg_rdata == 32'h0000_0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read not zero");

  property p_frozen;
    @(posedge ref_clk) disable iff (srst)
    !clk_en |=> $stable(upper_pin_function_select)
      && $stable(chip_select_pin_function) && $stable(pio_func_sel)
      && $stable(cfg_ack);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("state moved while enable low");
endmodule
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the pin function select block
`include "pin_mux_defs.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0; // system clock
  logic srst = 1'b1; // sync reset, high
  logic clk_en = 1'b1; // clock enable
  logic cfg_req = 1'b0; // request strobe
  logic cfg_wr = 1'b0; // write flag
  logic cfg_dword = 1'b0; // double width flag
  logic [11:0] cfg_addr = 12'h000; // byte offset
  logic [31:0] cfg_wdata = 32'h00000000; // write data
  logic [31:0] cfg_rdata; // read data
  logic cfg_ack, lower_wr_stb; // answer strobes
  logic [15:0] lower_wr_data, pio_func_sel; // lower data, routing
  logic [3:0] serial2_modem_sel; // modem routing
  logic cs0_sel, mem_sel, io_sel, oe_sel; // bus routing
  logic [7:0] bus_irq_sel, cs_func_sel; // irq and chip select
  int mismatches = 0; // failed compares
  int checks_done = 0; // compares made
  int cycles = 0; // timeout counter
  logic [31:0] seed = 32'h000103AD; // xorshift state
  logic [31:0] rd, r; // captured read data, random word
  logic acked, stb_seen; // answer flags
  logic [15:0] low_seen, cur; // lower half seen, model of upper
  pio_pin_function_select dut (.ref_clk(ref_clk), .srst(srst),
    .clk_en(clk_en), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
    .cfg_dword(cfg_dword), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
    .lower_wr_stb(lower_wr_stb), .lower_wr_data(lower_wr_data),
    .pio_func_sel(pio_func_sel), .serial2_modem_sel(serial2_modem_sel),
    .bus_chip_select_zero_sel(cs0_sel),
    .bus_wide_memory_indication_sel(mem_sel),
    .bus_wide_io_indication_sel(io_sel),
    .bus_data_buffer_output_enable_sel(oe_sel),
    .bus_irq_sel(bus_irq_sel), .cs_func_sel(cs_func_sel));
  // free running clock and hang guard
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      mismatches++;
      results();
    end
  end
  // xorshift random words
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // interrupt k follows select bit 7-k
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
  endfunction
  task automatic chk(input string name, input logic [31:0] exp,
    input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one access from a falling edge, waits for the answer
  task automatic access(input logic wr, input logic dw,
    input logic [11:0] a, input logic [31:0] d);
    cfg_req = 1'b1;
    cfg_wr = wr;
    cfg_dword = dw;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge ref_clk);
    cfg_req = 1'b0;
    {acked, stb_seen, rd} = {2'b00, 32'hFFFFFFFF};
    // answers show from the edge that takes the request; a double width ack comes one cycle later
    for (int i = 0; i < 4; i++)
    begin
      if (cfg_ack === 1'b1 && acked === 1'b0)
        {acked, rd} = {1'b1, cfg_rdata};
      if (lower_wr_stb === 1'b1 && acked === 1'b0)
        {stb_seen, low_seen} = {1'b1, lower_wr_data};
      @(negedge ref_clk);
    end
  endtask
  // all routing outputs against a select value
  task automatic route(input logic [15:0] v);
    chk("pio_func_sel", {16'h0000, v}, {16'h0000, pio_func_sel});
    chk("modem_bus_sel", {24'h000000, v[15:8]}, {24'h000000,
      serial2_modem_sel, cs0_sel, mem_sel, io_sel, oe_sel});
    chk("bus_irq_sel", {24'h000000, rev8(v[7:0])},
      {24'h000000, bus_irq_sel});
  endtask
  task automatic results();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(negedge ref_clk);
    srst = 1'b0;
    route(16'h0000);
    chk("cs_func_sel", 32'h0, {24'h000000, cs_func_sel});
    cur = 16'h0000;
    // walking ones then random upper selections
    for (int k = 0; k < 24; k++)
    begin
      r = xs();
      if (k < 16)
        r[15:0] = 16'h0001 << k;
      access(1'b1, 1'b0, `UPPER_SEL_OFFSET, r);
      chk("ack", 32'h1, {31'h0, acked});
      route(r[15:0]);
      cur = r[15:0];
      access(1'b0, 1'b0, `UPPER_SEL_OFFSET, xs());
      chk("upper read", {16'h0000, cur}, rd);
    end
    // chip select register, reserved bit forced high
    r = xs() | 32'h1;
    access(1'b1, 1'b0, `CS_SEL_OFFSET, r);
    chk("cs_func_sel", {24'h0, r[7:0] & 8'hFE}, {24'h0, cs_func_sel});
    access(1'b0, 1'b0, `CS_SEL_OFFSET, 32'h0);
    chk("cs read", {24'h0, r[7:0] & 8'hFE}, rd);
    // reserved bit written zero, as software should
    r = xs() & 32'hFFFFFFFE;
    access(1'b1, 1'b0, `CS_SEL_OFFSET, r);
    chk("cs_func_sel", {24'h0, r[7:0]}, {24'h0, cs_func_sel});
    // double width write splits lower then upper
    r = xs();
    access(1'b1, 1'b1, `LOWER_SEL_OFFSET, r);
    chk("lower first", 32'h1, {31'h0, stb_seen});
    chk("lower data", {16'h0, r[15:0]}, {16'h0, low_seen});
    route(r[31:16]);
    cur = r[31:16];
    access(1'b0, 1'b1, `LOWER_SEL_OFFSET, 32'h0);
    chk("dword read", {cur, 16'h0000}, rd);
    // unmapped places change nothing and read zero
    access(1'b1, 1'b0, 12'hC26, xs());
    access(1'b1, 1'b0, `LOWER_SEL_OFFSET, xs());
    route(cur);
    access(1'b0, 1'b0, 12'hC26, 32'h0);
    chk("unmapped read", 32'h0, rd);
    // frozen clock enable takes no request
    clk_en = 1'b0;
    access(1'b1, 1'b0, `UPPER_SEL_OFFSET, ~{16'h0, cur});
    chk("frozen ack", 32'h0, {31'h0, acked});
    clk_en = 1'b1;
    route(cur);
    // reset in mid run clears everything
    srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    route(16'h0000);
    chk("cs after reset", 32'h0, {24'h0, cs_func_sel});
    results();
  end
endmodule
`default_nettype wire
